// File: design/fault_priority_pick.sv
`timescale 1ns/1ps
module fault_priority_pick #(
    parameter int N = 11
) (
    // Active faults, bit i-1 is priority i
    input  wire logic [N-1:0] active,
    // Chosen priority, zero when none
    output logic      [3:0]   prio
);
    // Refuse widths that the 4-bit priority output cannot number
    if (N < 1 || N > 15) begin
        $error("fault_priority_pick: N out of range");
    end

    always_comb begin
        prio = 4'h0;
        for (int i = N; i >= 1; i--) begin
            if (active[i-1]) begin
                prio = 4'(i);
            end
        end
    end
endmodule

// File: design/spi_alt_error_status_encoder.sv
`timescale 1ns/1ps
// Behaviour
// - Detail code comes from faults captured at chip-select rise ending previous command.
// - Every sensor data response with a captured fault carries a 2-bit detail code naming the error class; fault-free ones leave it 00.
// - Alternative encoding used when alternative-status enable is set.
// - Oscillator, offset, temperature faults: basic 11, detail 00, echo and data kept.
// - Memory faults: detail 01, zero echo, data error code at least once.
// - Test mode: detail 10, zero echo, zero data; reset fault: error code.
// - Supply fault: detail 10, zeros until timer expiry, then code if unmasked.
// - MISO and transfer faults: basic 11, detail 11, zero echo, error code.
// - Register error frame: 0000, 11, 00, data high, data low, CRC byte.
// - Sensor error frame with data: C0, C3..1, 11, sample, res, detail, CRC.
// - Sensor error frame without data: zero command, 11, zero data, detail, CRC.
// - Data error code is 000 for unsigned samples, 800 for signed samples.
module spi_alt_error_status_encoder
    import status_enc_pkg::*;
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    // Chip select pin, active low
    input  wire logic                       cs_n,
    // Configuration
    input  wire logic                       alt_status_enable,
    input  wire logic                       supply_fault_mask,
    input  wire logic                       signed_data,
    input  wire logic                       supply_timer_expired,
    // Fault sources
    input  wire status_enc_pkg::fault_src_t faults,
    // Frame request
    input  wire logic                       req_valid,
    input  wire status_enc_pkg::frame_req_t req,
    // Response
    output logic                            resp_valid,
    output logic      [31:0]                resp_word,
    output logic      [1:0]                 detail_code,
    output logic      [3:0]                 captured_prio,
    output logic                            periodic_disable
);
    import status_enc_pkg::*;

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed {
        logic        cs_meta;
        logic        cs_sync;
        logic        cs_prev;
        logic [3:0]  prio;
        logic        code_owed;
        logic        supply_owed;
        logic        resp_valid;
        logic [31:0] resp_word;
        logic [1:0]  detail;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic [NUM_FAULTS-1:0] active;
    logic [3:0]            pick;
    logic                  cs_rise;
    logic [1:0]            det;
    logic                  keep_echo;
    logic                  zero_data;
    logic                  send_code;
    logic [11:0]           err_code;
    logic [11:0]           sd_field;
    logic [3:0]            cmd_field;
    logic                  use_code;

    //--------------------------------------------------------------
    // Fault ordering
    //--------------------------------------------------------------
    always_comb begin
        active                = '0;
        active[PRIO_SPI-1]    = faults.spi;
        active[PRIO_MISO-1]   = faults.miso;
        active[PRIO_RESET-1]  = faults.reset_occurred_flag;
        active[PRIO_SUPPLY-1] = faults.supply;
        active[PRIO_TEST-1]   = faults.factory_check_flag;
        active[PRIO_F_OTP-1]  = faults.factory_otp;
        active[PRIO_U_RW-1]   = faults.user_rw;
        active[PRIO_U_OTP-1]  = faults.user_otp;
        active[PRIO_TEMP-1]   = faults.temperature;
        // Clipping counts only under the standard encoding
        active[PRIO_OFFSET-1] = faults.offset | (faults.signal_clip & ~alt_status_enable);
        active[PRIO_OSC-1]    = faults.osc_train;
    end

    fault_priority_pick #(
        .N      (NUM_FAULTS)
    ) u_pick (
        .active (active),
        .prio   (pick)
    );

    //--------------------------------------------------------------
    // Class decode of the captured fault
    //--------------------------------------------------------------
    always_comb begin
        det       = DETAIL_DATA;
        keep_echo = 1'b0;
        zero_data = 1'b0;
        send_code = 1'b0;
        case (st_reg.prio)
            4'(PRIO_OSC), 4'(PRIO_OFFSET), 4'(PRIO_TEMP): begin
                det       = DETAIL_DATA;
                keep_echo = 1'b1;
            end
            4'(PRIO_U_OTP), 4'(PRIO_U_RW), 4'(PRIO_F_OTP): begin
                det       = DETAIL_MEMORY;
                send_code = 1'b1;
            end
            4'(PRIO_TEST): begin
                det       = DETAIL_MODE;
                zero_data = 1'b1;
            end
            4'(PRIO_SUPPLY): begin
                det       = DETAIL_MODE;
                // Zeros until the monitor expires, then one code if unmasked
                zero_data = ~(supply_timer_expired & st_reg.supply_owed);
                send_code = supply_timer_expired & st_reg.supply_owed;
            end
            4'(PRIO_RESET): begin
                det       = DETAIL_MODE;
                send_code = 1'b1;
            end
            4'(PRIO_MISO), 4'(PRIO_SPI): begin
                det       = DETAIL_COMM;
                send_code = 1'b1;
            end
            default: begin
                det       = DETAIL_DATA;
                keep_echo = 1'b1;
            end
        endcase
    end

    assign err_code = signed_data ? SD_ERR_SIGNED : SD_ERR_UNSIGNED;
    assign use_code = send_code & (st_reg.code_owed | (st_reg.prio == 4'(PRIO_SUPPLY)));

    always_comb begin
        cmd_field = keep_echo ? {req.cmd[0], req.cmd[3:1]} : 4'h0;
        if (zero_data) begin
            sd_field = 12'h000;
        end else if (use_code) begin
            sd_field = err_code;
        end else begin
            sd_field = req.sample_value;
        end
    end

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    assign cs_rise = st_reg.cs_sync & ~st_reg.cs_prev;

    always_comb begin
        st_next            = st_reg;
        st_next.cs_meta    = cs_n;
        st_next.cs_sync    = st_reg.cs_meta;
        st_next.cs_prev    = st_reg.cs_sync;
        st_next.resp_valid = 1'b0;
        if (req_valid) begin
            st_next.resp_valid = 1'b1;
            st_next.detail     = det;
            st_next.resp_word  = FRAME_RESET;
            case (req.kind)
                KIND_REGISTER: begin
                    if (st_reg.prio != 4'h0) begin
                        st_next.resp_word[BASIC_LSB+1:BASIC_LSB] = BASIC_ERROR;
                    end else begin
                        st_next.resp_word[BASIC_LSB+1:BASIC_LSB] = req.basic_condition_code;
                    end
                    st_next.resp_word[RDHI_LSB+7:RDHI_LSB] = req.reg_data[15:8];
                    st_next.resp_word[RDLO_LSB+7:RDLO_LSB] = req.reg_data[7:0];
                end
                KIND_SENSOR_DATA: begin
                    if (st_reg.prio != 4'h0) begin
                        st_next.resp_word[CMD_MSB:CMD_MSB-3]      = cmd_field;
                        st_next.resp_word[BASIC_LSB+1:BASIC_LSB]  = BASIC_ERROR;
                        st_next.resp_word[SD_LSB+11:SD_LSB]       = sd_field;
                        st_next.resp_word[DETAIL_LSB+1:DETAIL_LSB] = det;
                        if (!zero_data && !use_code) begin
                            st_next.resp_word[SDRES_LSB+3:SDRES_LSB] = req.sample_res;
                        end
                    end else begin
                        st_next.resp_word[CMD_MSB:CMD_MSB-3]      = {req.cmd[0], req.cmd[3:1]};
                        st_next.resp_word[BASIC_LSB+1:BASIC_LSB]  = req.basic_condition_code;
                        st_next.resp_word[SD_LSB+11:SD_LSB]       = req.sample_value;
                        st_next.resp_word[SDRES_LSB+3:SDRES_LSB]  = req.sample_res;
                    end
                end
                KIND_SENSOR_NODATA: begin
                    st_next.resp_word[BASIC_LSB+1:BASIC_LSB] = (st_reg.prio != 4'h0)
                        ? BASIC_ERROR : req.basic_condition_code;
                    st_next.resp_word[DETAIL_LSB+1:DETAIL_LSB] = det;
                end
                default: begin
                    st_next.resp_word = FRAME_RESET;
                end
            endcase
            // Error code goes out once per capture (supply: once per run of consecutive supply captures), then normal data may follow
            if (req.kind == KIND_SENSOR_DATA && use_code) begin
                st_next.code_owed = 1'b0;
                if (st_reg.prio == 4'(PRIO_SUPPLY)) begin
                    st_next.supply_owed = 1'b0;
                end
            end
        end
        // Capture at chip-select release; the capture wins over consumption, except that a supply code still owed stays consumed
        if (cs_rise) begin
            st_next.prio        = pick;
            st_next.code_owed   = 1'b1;
            if (pick != 4'(PRIO_SUPPLY) || !st_reg.supply_owed) begin
                st_next.supply_owed = (pick == 4'(PRIO_SUPPLY)) & ~supply_fault_mask
                                      & (st_reg.prio != 4'(PRIO_SUPPLY) | st_reg.supply_owed);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_reg         <= '0;
            st_reg.cs_meta <= 1'b1;
            st_reg.cs_sync <= 1'b1;
            st_reg.cs_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign resp_valid       = st_reg.resp_valid;
    assign resp_word        = st_reg.resp_word;
    assign detail_code      = st_reg.detail;
    assign captured_prio    = st_reg.prio;
    assign periodic_disable = (st_reg.prio == 4'(PRIO_SUPPLY)) & ~supply_fault_mask;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    sequence cs_release;
        $rose(st_reg.cs_sync) ##0 st_reg.cs_prev == 1'b0;
    endsequence

    sequence sensor_req;
        req_valid && req.kind == KIND_SENSOR_DATA;
    endsequence

    AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (!resetn)
        cs_release |=> captured_prio == $past(pick))
        else $error("fault not captured at chip-select release");

    AST_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!resetn)
        req_valid |=> resp_valid ##1 (!resp_valid || $past(req_valid)))
        else $error("response valid not one cycle after request");

    AST_REG_FRAME: assert property (@(posedge sys_clk) disable iff (!resetn)
        req_valid && req.kind == KIND_REGISTER && captured_prio != 4'h0
        |=> resp_word[31:24] == 8'h0C && resp_word[23:8] == $past(req.reg_data))
        else $error("register error frame malformed");

    AST_ECHO: assert property (@(posedge sys_clk) disable iff (!resetn)
        sensor_req ##0 (captured_prio >= 4'(PRIO_TEMP) && !cs_rise)
        |=> resp_word[31:28] == {$past(req.cmd[0]), $past(req.cmd[3:1])}
            && resp_word[9:8] == DETAIL_DATA)
        else $error("echo lost for data-class fault");

    AST_MEM: assert property (@(posedge sys_clk) disable iff (!resetn)
        sensor_req ##0 captured_prio inside {4'h6, 4'h7, 4'h8}
        |=> resp_word[31:28] == 4'h0 && resp_word[9:8] == DETAIL_MEMORY)
        else $error("memory fault frame wrong");

    AST_TEST: assert property (@(posedge sys_clk) disable iff (!resetn)
        sensor_req ##0 captured_prio == 4'(PRIO_TEST)
        |=> resp_word[25:10] == 16'h0000 && resp_word[9:8] == DETAIL_MODE)
        else $error("test mode frame not zero");

    AST_SUPPLY: assert property (@(posedge sys_clk) disable iff (!resetn)
        sensor_req ##0 captured_prio == 4'(PRIO_SUPPLY) ##0 !supply_timer_expired
        |=> resp_word[25:14] == 12'h000)
        else $error("supply fault sent data before timer expiry");

    AST_COMM: assert property (@(posedge sys_clk) disable iff (!resetn)
        sensor_req ##0 captured_prio inside {4'h1, 4'h2} ##0 st_reg.code_owed
        |=> resp_word[27:26] == BASIC_ERROR && resp_word[9:8] == DETAIL_COMM
            && resp_word[25:14] == $past(err_code))
        else $error("transfer fault frame wrong");

    AST_NODATA: assert property (@(posedge sys_clk) disable iff (!resetn)
        req_valid && req.kind == KIND_SENSOR_NODATA && captured_prio != 4'h0
        |=> resp_word[31:26] == 6'h03 && resp_word[24:10] == 15'h0000)
        else $error("no-data error frame malformed");

    AST_CODE_VAL: assert property (@(posedge sys_clk) disable iff (!resetn)
        sensor_req ##0 use_code
        |=> resp_word[25:14] == ($past(signed_data) ? SD_ERR_SIGNED : SD_ERR_UNSIGNED))
        else $error("data error code wrong");

endmodule

// File: design/status_enc_pkg.sv
package status_enc_pkg;

    // Fault priorities, 1 is the most urgent
    localparam int PRIO_SPI      = 1;
    localparam int PRIO_MISO     = 2;
    localparam int PRIO_RESET    = 3;
    localparam int PRIO_SUPPLY   = 4;
    localparam int PRIO_TEST     = 5;
    localparam int PRIO_F_OTP    = 6;
    localparam int PRIO_U_RW     = 7;
    localparam int PRIO_U_OTP    = 8;
    localparam int PRIO_TEMP     = 9;
    localparam int PRIO_OFFSET   = 10;
    localparam int PRIO_OSC      = 11;
    localparam int NUM_FAULTS    = 11;
    localparam int PRIO_W        = 4;

    // Basic and detailed status codes
    localparam logic [1:0] BASIC_ERROR   = 2'h3;
    localparam logic [1:0] DETAIL_DATA   = 2'h0;
    localparam logic [1:0] DETAIL_MEMORY = 2'h1;
    localparam logic [1:0] DETAIL_MODE   = 2'h2;
    localparam logic [1:0] DETAIL_COMM   = 2'h3;

    // Sensor data field error codes
    localparam logic [11:0] SD_ERR_UNSIGNED = 12'h000;
    localparam logic [11:0] SD_ERR_SIGNED   = 12'h800;

    // Frame field positions
    localparam int CMD_MSB    = 31;
    localparam int BASIC_LSB  = 26;
    localparam int RDHI_LSB   = 16;
    localparam int RDLO_LSB   = 8;
    localparam int SD_LSB     = 14;
    localparam int SDRES_LSB  = 10;
    localparam int DETAIL_LSB = 8;

    localparam logic [31:0] FRAME_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        KIND_REGISTER,
        KIND_SENSOR_DATA,
        KIND_SENSOR_NODATA
    } frame_kind_t;

    // Fault sources sampled at chip-select release
    typedef struct packed {
        logic osc_train;
        logic offset;
        logic signal_clip;
        logic temperature;
        logic user_otp;
        logic user_rw;
        logic factory_otp;
        logic factory_check_flag;
        logic supply;
        logic reset_occurred_flag;
        logic miso;
        logic spi;
    } fault_src_t;

    // One frame request from the transfer logic
    typedef struct packed {
        frame_kind_t kind;
        logic [3:0]  cmd;
        logic [15:0] reg_data;
        logic [11:0] sample_value;
        logic [3:0]  sample_res;
        logic [1:0]  basic_condition_code;
    } frame_req_t;

endpackage

// File: testbench/spi_alt_error_status_encoder_bench.sv
`timescale 1ns/1ps
module spi_alt_error_status_encoder_bench;
    import status_enc_pkg::*;

    logic        sys_clk, resetn, cs_n, link_clk, alt_status_enable, supply_fault_mask;
    logic        signed_data, supply_timer_expired, req_valid, resp_valid;
    logic        periodic_disable, data_suspect, first;
    fault_src_t  faults;
    frame_req_t  req;
    logic [31:0] resp_word, seed, v;
    logic [1:0]  detail_code;
    logic [3:0]  captured_prio, cp;
    logic [34:0] notes[$];
    logic [34:0] n;
    int          mismatches, compares, cycles;

    spi_alt_error_status_encoder u_spi_alt_error_status_encoder (
        .sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
        .alt_status_enable(alt_status_enable), .supply_fault_mask(supply_fault_mask),
        .signed_data(signed_data), .supply_timer_expired(supply_timer_expired),
        .faults(faults), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
        .resp_word(resp_word), .detail_code(detail_code), .captured_prio(captured_prio),
        .periodic_disable(periodic_disable));

    spi_master_model u_spi_master_model (
        .cs_n(cs_n), .link_clk(link_clk), .resp_valid(resp_valid),
        .resp_word(resp_word), .data_suspect(data_suspect));

    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task close_out;
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function logic [3:0] prio_of(input fault_src_t f, input logic alt);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (f[i] && (i != 9 || !alt)) p = (i < 9) ? 4'(i + 1) : ((i == 11) ? 4'hB : 4'hA);
        end
        return p;
    endfunction

    function logic [34:0] expect_frame(input frame_req_t r);
        logic [1:0]  b, d;
        logic [3:0]  e, res;
        logic [11:0] sd, code;
        logic        err;
        code = signed_data ? SD_ERR_SIGNED : SD_ERR_UNSIGNED;
        b = (cp == 4'h0) ? r.basic_condition_code : BASIC_ERROR;
        d = (cp == 4'h0 || cp > 4'h8) ? DETAIL_DATA : (cp > 4'h5) ? DETAIL_MEMORY :
            (cp > 4'h2) ? DETAIL_MODE : DETAIL_COMM;
        err = first && (cp != 4'h4 || (supply_timer_expired && !supply_fault_mask));
        e = {r.cmd[0], r.cmd[3:1]};
        sd = r.sample_value;
        res = r.sample_res;
        if (cp != 4'h0 && cp < 4'h9) begin
            e = 4'h0;
            if (cp == 4'h4 || cp == 4'h5) begin
                sd = 12'h000;
                res = 4'h0;
            end
            if (err && cp != 4'h5) begin
                sd = code;
                res = 4'h0;
            end
        end
        if (r.kind == KIND_REGISTER) return {3'h0, 4'h0, b, 2'h0, r.reg_data, 8'h00};
        if (r.kind == KIND_SENSOR_NODATA) return {1'h1, d, 4'h0, b, 16'h0000, d, 8'h00};
        return {1'h1, d, e, b, sd, res, d, 8'h00};
    endfunction

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    function frame_req_t mk(input frame_kind_t k);
        logic [31:0] w;
        w = rnd();
        return '{kind: k, cmd: w[3:0], reg_data: w[31:16], sample_value: w[15:4],
                 sample_res: w[7:4], basic_condition_code: w[9:8]};
    endfunction

    task send(input frame_req_t r);
        @(posedge sys_clk);
        req_valid <= 1'h1;
        req <= r;
        notes.push_back(expect_frame(r));
        if (r.kind == KIND_SENSOR_DATA && cp != 4'h0 && cp < 4'h9 && cp != 4'h5 &&
            (cp != 4'h4 || (supply_timer_expired && !supply_fault_mask))) first = 1'h0;
    endtask

    task idle;
        @(posedge sys_clk);
        req_valid <= 1'h0;
    endtask

    task burst;
        send(mk(KIND_SENSOR_DATA));
        send(mk(KIND_SENSOR_DATA));
        send(mk(KIND_SENSOR_NODATA));
        send(mk(KIND_REGISTER));
        idle();
    endtask

    task capture(input fault_src_t f);
        @(posedge sys_clk);
        faults <= f;
        @(posedge sys_clk);
        u_spi_master_model.frame();
        repeat (6) @(posedge sys_clk);
        cp = prio_of(f, alt_status_enable);
        first = 1'h1;
        check("captured_prio", 32'(captured_prio), 32'(cp));
        faults <= fault_src_t'(12'(rnd()));
    endtask

    always @(negedge sys_clk) begin
        if (resp_valid === 1'h1) begin
            n = notes.pop_front();
            check("resp_word", resp_word, n[31:0]);
            check("data_suspect", 32'(data_suspect), 32'(n[27:26] == BASIC_ERROR));
            if (n[34]) check("detail_code", 32'(detail_code), 32'(n[33:32]));
        end
    end

    initial begin
        seed = 32'h2DD7;
        resetn = 1'h0;
        alt_status_enable = 1'h1;
        supply_fault_mask = 1'h0;
        signed_data = 1'h0;
        supply_timer_expired = 1'h0;
        faults = '0;
        req_valid = 1'h0;
        req = '0;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        cp = 4'h0;
        first = 1'h0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'h1;
        @(posedge sys_clk);
        check("resp_word", resp_word, 32'h0000_0000);
        capture('0);
        burst();
        for (int i = 0; i < 12; i++) begin
            if (i != 3) begin
                signed_data <= i[0];
                capture(fault_src_t'(12'h001 << i));
                burst();
            end
        end
        alt_status_enable <= 1'h0;
        capture(fault_src_t'(12'h200));
        burst();
        alt_status_enable <= 1'h1;
        for (int m = 0; m < 2; m++) begin
            supply_fault_mask <= m[0];
            supply_timer_expired <= 1'h0;
            capture(fault_src_t'(12'h008));
            check("periodic_disable", 32'(periodic_disable), 32'(!m[0]));
            send(mk(KIND_SENSOR_DATA));
            idle();
            supply_timer_expired <= 1'h1;
            burst();
        end
        repeat (16) begin
            v = rnd();
            signed_data <= v[12];
            capture(fault_src_t'(v[11:0] & 12'hFF7));
            burst();
        end
        repeat (4) @(posedge sys_clk);
        close_out();
    end
endmodule

// File: testbench/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model
    import status_enc_pkg::*;
(
    // Link pins
    output logic             cs_n,
    output logic             link_clk,
    // Response watch
    input  wire logic        resp_valid,
    input  wire logic [31:0] resp_word,
    output logic             data_suspect
);
    import status_enc_pkg::*;

    initial begin
        cs_n = 1'h1;
        link_clk = 1'h0;
    end

    // Any answer marked with an error class is not trusted
    assign data_suspect = resp_valid && (resp_word[27:26] == BASIC_ERROR);

    // One 32-clock transfer; the link clock rests low outside frames
    task frame;
        // Step off the system clock edge before selecting
        #1;
        cs_n = 1'h0;
        #20;
        repeat (32) begin
            link_clk = 1'h1;
            #24;
            link_clk = 1'h0;
            #24;
        end
        #20;
        cs_n = 1'h1;
    endtask
endmodule
